// ==== common/tsoc_pkg.sv ====
// Purpose: constants and types for the four-channel timer status/output control block
// Assumes: one 40 MHz clock, synchronous active-high reset
// Notes: rule summary below
// Function
// - flag bits 7..5 are cleared only by writing 0; writing 1 does nothing
// - reset or standby loads channel 2 status with 0x10, others with 0x00
// - a zero write clears a flag only after it was read while set
// - match-b flag sets on counter equal compare b, or on capture into b
// - capture select in channel 1/3 blocks channel 0/2 match-b flag setting
// - match-a flag in bit 6 sets when counter equals compare a
// - overflow flag in bit 5 sets when counter wraps from max to zero
// - converter trigger enable gates starts; adc enable picks match a over pin
// - reserved bit 4 in channel 2 stays readable and writable storage
// - capture select 0 makes register b compare, 1 makes it capture
// - with capture select, paired lower channel gives no b output or b interrupt
// - with capture select, pin is capture input; capture sets b flag and interrupt
// - compare a keeps working in all channels with capture select set; here channel 1/3 pin output enable is forced off by it
// - b action field: 00 hold, 01 drive 0, 10 drive 1, 11 toggle
// - in capture mode b field picks rising, falling or both edges; 11 forbidden
// - a action field: 00 hold, 01 drive 0, 10 drive 1, 11 toggle
// - simultaneous a and b matches follow priority toggle, then 1, then 0
// - all four action bits zero disables the timer output
// - match interrupt requests are flag and enable together
// - overflow interrupt request is flag and enable together
package tsoc_pkg;
   localparam int unsigned num_ch = 4;
   localparam logic [7:0] reset_ch2 = 8'h10;
   localparam logic [7:0] reset_other = 8'h00;
   localparam logic [7:0] counter_max = 8'hff;
   localparam int unsigned bit_flag_b = 7;
   localparam int unsigned bit_flag_a = 6;
   localparam int unsigned bit_flag_overflow = 5;
   localparam int unsigned bit_four = 4;
   localparam logic [1:0] act_hold = 2'h0;
   localparam logic [1:0] act_zero = 2'h1;
   localparam logic [1:0] act_one = 2'h2;
   localparam logic [1:0] act_toggle = 2'h3;
   localparam logic [1:0] edge_rise = 2'h0;
   localparam logic [1:0] edge_fall = 2'h1;
   localparam logic [1:0] edge_both = 2'h2;

   // decoded view of one status/control byte
   typedef struct packed {
      logic match_b_flag;
      logic match_a_flag;
      logic overflow_flag;
      logic bit4;
      logic [1:0] b_action;
      logic [1:0] a_action;
   } status_t;

   // per-channel events from the counter side
   typedef struct packed {
      logic match_a;
      logic match_b;
      logic overflow;
   } events_t;
endpackage : tsoc_pkg

// ==== rtl/pin_sync.sv ====
// Purpose: three-stage synchroniser with agreement filter for a pin
// Assumes: input asynchronous to clk_in
// Notes: level changes when stages two and three agree
`timescale 1ns/1ps
module pin_sync
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic pin_in,
   output logic level_out
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end
      else
      begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // only the agreeing stages decide, stage one is never looked at
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         level_out <= 1'b0;
      else if (s2_q == s3_q)
         level_out <= s3_q;
   end
endmodule : pin_sync

// ==== rtl/pin_action.sv ====
// Purpose: resolves compare-match a and b actions onto one timer pin
// Assumes: matches are one-cycle pulses
// Notes: output is disabled while all action bits are zero
`timescale 1ns/1ps
module pin_action
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic match_a_in,
   input wire logic match_b_in,
   input wire logic [1:0] a_action_in,
   input wire logic [1:0] b_action_in,
   output logic level_out,
   output logic enable_out
);
   logic [1:0] eff_a;
   logic [1:0] eff_b;
   logic [1:0] win;

   // toggle(11) > one(10) > zero(01) > hold(00): numeric max gives the order
   always_comb
   begin
      eff_a = match_a_in ? a_action_in : tsoc_pkg::act_hold;
      eff_b = match_b_in ? b_action_in : tsoc_pkg::act_hold;
      win = (eff_a > eff_b) ? eff_a : eff_b;
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         level_out <= 1'b0;
      else
      begin
         unique case (win)
            tsoc_pkg::act_hold: level_out <= level_out;
            tsoc_pkg::act_zero: level_out <= 1'b0;
            tsoc_pkg::act_one: level_out <= 1'b1;
            tsoc_pkg::act_toggle: level_out <= ~level_out;
         endcase
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         enable_out <= 1'b0;
      else
         enable_out <= |{a_action_in, b_action_in};
   end
endmodule : pin_action

// ==== rtl/timer_status_output_control.sv ====
// Purpose: status/control bytes, flags, pin actions, capture and adc gating for four channels
// Assumes: counter, compare registers and matches come from a counter block on clk_in
// Notes: byte register port per channel; reads are registered one cycle later
`timescale 1ns/1ps
module timer_status_output_control
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic standby_in,
   // cpu byte access: select picks the channel
   input wire logic [1:0] reg_sel_in,
   input wire logic reg_rd_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   // counter side
   input wire tsoc_pkg::events_t [3:0] events_in,
   input wire logic [31:0] counter_in,
   // interrupt enables per channel
   input wire logic [3:0] match_a_irq_enable_in,
   input wire logic [3:0] match_b_irq_enable_in,
   input wire logic [3:0] overflow_irq_enable_in,
   // capture pins of channels 1 and 3
   input wire logic capture_pin1_in,
   input wire logic capture_pin3_in,
   // converter link
   input wire logic converter_trigger_enable_in,
   input wire logic adc_external_trigger_pin_in,
   output logic adc_start_out,
   // pins and captured values
   output logic [3:0] timer_pin_out,
   output logic [3:0] timer_pin_oe_out,
   output logic [15:0] capture_value_out,
   output logic [1:0] capture_load_out,
   output logic [3:0] match_a_interrupt_out,
   output logic [3:0] match_b_interrupt_out,
   output logic [3:0] overflow_interrupt_out,
   output logic [7:0] status_ch0_out,
   output logic [7:0] status_ch1_out,
   output logic [7:0] status_ch2_out,
   output logic [7:0] status_ch3_out
);
   // ************************************************************
   // state
   // ************************************************************
   tsoc_pkg::status_t [3:0] stat_q;
   logic [3:0][2:0] armed_q;
   logic [3:0] pin_lvl;
   logic [3:0] pin_en;
   logic [1:0] cap_lvl;
   logic [1:0] cap_prev_q;
   logic [1:0] cap_evt;
   logic [3:0] b_set;
   logic [3:0] a_set;
   logic [3:0] o_set;
   logic [3:0] b_pin;
   logic [3:0] wr_hit;
   logic adc_sync;
   logic init;

   assign init = reset_in | standby_in;

   function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic now);
      logic rise;
      logic fall;
      rise = ~prev & now;
      fall = prev & ~now;
      unique case (sel)
         tsoc_pkg::edge_rise: edge_hit = rise;
         tsoc_pkg::edge_fall: edge_hit = fall;
         tsoc_pkg::edge_both: edge_hit = rise | fall;
         default: edge_hit = 1'b0;
      endcase
   endfunction : edge_hit

   function automatic logic valid_clear(input logic wr, input logic wbit, input logic armed);
      valid_clear = wr & ~wbit & armed;
   endfunction : valid_clear

   // ************************************************************
   // capture inputs
   // ************************************************************
   pin_sync u_sync1
   (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .pin_in(capture_pin1_in),
      .level_out(cap_lvl[0])
   );
   pin_sync u_sync3
   (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .pin_in(capture_pin3_in),
      .level_out(cap_lvl[1])
   );
   pin_sync u_sync_adc
   (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .pin_in(adc_external_trigger_pin_in),
      .level_out(adc_sync)
   );

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         cap_prev_q <= 2'h0;
      else
         cap_prev_q <= cap_lvl;
   end

   // the upper channel's edge field chooses the capture edge
   always_comb
   begin
      cap_evt[0] = stat_q[1].bit4 & edge_hit(stat_q[1].b_action, cap_prev_q[0], cap_lvl[0]);
      cap_evt[1] = stat_q[3].bit4 & edge_hit(stat_q[3].b_action, cap_prev_q[1], cap_lvl[1]);
   end

   always_ff @(posedge clk_in)
   begin
      if (init)
      begin
         capture_value_out <= 16'h0000;
         capture_load_out <= 2'h0;
      end
      else
      begin
         capture_load_out <= cap_evt;
         if (cap_evt[0])
            capture_value_out[7:0] <= counter_in[15:8];
         if (cap_evt[1])
            capture_value_out[15:8] <= counter_in[31:24];
      end
   end

   // ************************************************************
   // flag set sources
   // ************************************************************
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         a_set[i] = events_in[i].match_a;
         o_set[i] = events_in[i].overflow;
         wr_hit[i] = reg_wr_in && reg_sel_in == i[1:0];
      end
      b_pin[0] = events_in[0].match_b & ~stat_q[1].bit4;
      b_pin[2] = events_in[2].match_b & ~stat_q[3].bit4;
      b_pin[1] = events_in[1].match_b & ~stat_q[1].bit4;
      b_pin[3] = events_in[3].match_b & ~stat_q[3].bit4;
      b_set[0] = b_pin[0];
      b_set[2] = b_pin[2];
      b_set[1] = b_pin[1] | cap_evt[0];
      b_set[3] = b_pin[3] | cap_evt[1];
   end

   // ************************************************************
   // read arming: a flag read as 1 may then be cleared
   // ************************************************************
   always_ff @(posedge clk_in)
   begin
      if (init)
         armed_q <= '0;
      else
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (reg_rd_in && reg_sel_in == i[1:0])
               armed_q[i] <= {stat_q[i].match_b_flag, stat_q[i].match_a_flag, stat_q[i].overflow_flag};
            // a write spends the arming, so a flag set again needs a fresh read
            else if (wr_hit[i])
               armed_q[i] <= 3'h0;
         end
      end
   end

   // ************************************************************
   // status/control registers
   // ************************************************************
   always_ff @(posedge clk_in)
   begin
      if (init)
      begin
         for (int i = 0; i < 4; i++)
            stat_q[i] <= (i == 2) ? tsoc_pkg::reset_ch2 : tsoc_pkg::reset_other;
      end
      else
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (wr_hit[i])
            begin
               stat_q[i].bit4 <= reg_wdata_in[tsoc_pkg::bit_four];
               stat_q[i].b_action <= reg_wdata_in[3:2];
               stat_q[i].a_action <= reg_wdata_in[1:0];
            end
            // set dominates a same-cycle clear
            if (b_set[i])
               stat_q[i].match_b_flag <= 1'b1;
            else if (valid_clear(wr_hit[i], reg_wdata_in[tsoc_pkg::bit_flag_b], armed_q[i][2]))
               stat_q[i].match_b_flag <= 1'b0;
            if (a_set[i])
               stat_q[i].match_a_flag <= 1'b1;
            else if (valid_clear(wr_hit[i], reg_wdata_in[tsoc_pkg::bit_flag_a], armed_q[i][1]))
               stat_q[i].match_a_flag <= 1'b0;
            if (o_set[i])
               stat_q[i].overflow_flag <= 1'b1;
            else if (valid_clear(wr_hit[i], reg_wdata_in[tsoc_pkg::bit_flag_overflow], armed_q[i][0]))
               stat_q[i].overflow_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (init)
         reg_rdata_out <= 8'h00;
      else if (reg_rd_in)
         reg_rdata_out <= stat_q[reg_sel_in];
   end

   always_ff @(posedge clk_in)
   begin
      if (init)
      begin
         status_ch0_out <= tsoc_pkg::reset_other;
         status_ch1_out <= tsoc_pkg::reset_other;
         status_ch2_out <= tsoc_pkg::reset_ch2;
         status_ch3_out <= tsoc_pkg::reset_other;
      end
      else
      begin
         status_ch0_out <= stat_q[0];
         status_ch1_out <= stat_q[1];
         status_ch2_out <= stat_q[2];
         status_ch3_out <= stat_q[3];
      end
   end

   // ************************************************************
   // interrupt requests
   // ************************************************************
   always_ff @(posedge clk_in)
   begin
      if (init)
      begin
         match_a_interrupt_out <= 4'h0;
         match_b_interrupt_out <= 4'h0;
         overflow_interrupt_out <= 4'h0;
      end
      else
      begin
         for (int i = 0; i < 4; i++)
         begin
            match_a_interrupt_out[i] <= stat_q[i].match_a_flag & match_a_irq_enable_in[i];
            match_b_interrupt_out[i] <= stat_q[i].match_b_flag & match_b_irq_enable_in[i];
            overflow_interrupt_out[i] <= stat_q[i].overflow_flag & overflow_irq_enable_in[i];
         end
      end
   end

   // ************************************************************
   // pins
   // ************************************************************
   for (genvar g = 0; g < 4; g++)
   begin : g_pin
      pin_action u_act
      (
         .clk_in(clk_in),
         .reset_in(init),
         .match_a_in(events_in[g].match_a),
         .match_b_in(b_pin[g]),
         .a_action_in(stat_q[g].a_action),
         .b_action_in(stat_q[g].b_action),
         .level_out(pin_lvl[g]),
         .enable_out(pin_en[g])
      );
   end

   always_ff @(posedge clk_in)
   begin
      if (init)
      begin
         timer_pin_out <= 4'h0;
         timer_pin_oe_out <= 4'h0;
      end
      else
      begin
         timer_pin_out <= pin_lvl;
         timer_pin_oe_out[0] <= pin_en[0];
         timer_pin_oe_out[2] <= pin_en[2];
         timer_pin_oe_out[1] <= pin_en[1] & ~stat_q[1].bit4;
         timer_pin_oe_out[3] <= pin_en[3] & ~stat_q[3].bit4;
      end
   end

   // ************************************************************
   // converter start gating
   // ************************************************************
   always_ff @(posedge clk_in)
   begin
      if (init)
         adc_start_out <= 1'b0;
      else if (!converter_trigger_enable_in)
         adc_start_out <= 1'b0;
      else if (stat_q[0].bit4)
         adc_start_out <= events_in[0].match_a;
      else
         adc_start_out <= adc_sync;
   end

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (init);

   flag_a_set_a: assert property (events_in[0].match_a |=> stat_q[0].match_a_flag)
      else $error("match a flag not set");
   overflow_set_a: assert property (events_in[3].overflow |=> stat_q[3].overflow_flag)
      else $error("overflow flag not set");
   b_block_a: assert property (stat_q[1].bit4 && events_in[0].match_b && !stat_q[0].match_b_flag
      |=> !stat_q[0].match_b_flag)
      else $error("match b flag set while capture selected");
   cap_flag_a: assert property (cap_evt[1] |=> stat_q[3].match_b_flag && capture_load_out[1])
      else $error("capture did not set flag");
   no_blind_clear_a: assert property (wr_hit[0] && !armed_q[0][1]
      && stat_q[0].match_a_flag |=> stat_q[0].match_a_flag)
      else $error("flag cleared without read");
   set_wins_a: assert property (events_in[0].match_a && wr_hit[0] |=> stat_q[0].match_a_flag)
      else $error("set lost against clear");
   irq_b_a: assert property (##1 match_b_interrupt_out[0] ==
      $past(stat_q[0].match_b_flag & match_b_irq_enable_in[0]))
      else $error("match b interrupt mismatch");
   irq_overflow_a: assert property (overflow_interrupt_out[0] |-> $past(stat_q[0].overflow_flag))
      else $error("overflow interrupt without flag");
   adc_off_a: assert property (!converter_trigger_enable_in |=> !adc_start_out)
      else $error("adc start while disabled");
   oe_off_a: assert property (stat_q[1].b_action == 2'h0 && stat_q[1].a_action == 2'h0
      ##1 stat_q[1] == $past(stat_q[1]) |=> !timer_pin_oe_out[1])
      else $error("pin enabled with zero actions");

   cap_seen_c: cover property (cap_evt[0]);
   clear_seen_c: cover property (stat_q[0].match_a_flag ##1 !stat_q[0].match_a_flag);
   toggle_seen_c: cover property (timer_pin_out[0] != $past(timer_pin_out[0]));
   set_clear_c: cover property (events_in[0].match_a && wr_hit[0]);
endmodule : timer_status_output_control

// ==== testbench/counter_side_model.sv ====
// Purpose: counter-side partner feeding match and overflow events and counts
// Assumes: counters are loaded before they are stepped
// Notes: events are combinational from the step so they can meet a write edge
`timescale 1ns/1ps
module counter_side_model
(
   input wire logic clk_in,
   input wire logic [3:0] step_in,
   input wire logic [3:0] load_in,
   input wire logic [7:0] load_val_in,
   input wire logic [31:0] cmp_a_in,
   input wire logic [31:0] cmp_b_in,
   output tsoc_pkg::events_t [3:0] events_out,
   output logic [31:0] counter_out
);
   logic [7:0] cnt_q [4];

   always_ff @(posedge clk_in)
   begin
      for (int i = 0; i < 4; i++)
      begin
         if (load_in[i])
         begin
            cnt_q[i] <= load_val_in;
         end
         else if (step_in[i])
         begin
            cnt_q[i] <= cnt_q[i] + 8'h01;
         end
      end
   end

   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         counter_out[i*8 +: 8] = cnt_q[i];
         events_out[i].match_a = step_in[i] && (cnt_q[i] == cmp_a_in[i*8 +: 8]);
         events_out[i].match_b = step_in[i] && (cnt_q[i] == cmp_b_in[i*8 +: 8]);
         events_out[i].overflow = step_in[i] && (cnt_q[i] == 8'hff);
      end
   end
endmodule : counter_side_model

// ==== testbench/timer_status_output_control_test.sv ====
// Purpose: self-checking bench for the timer status/output control block
// Assumes: counter_side_model supplies events; pins are driven here
// Notes: reference model keeps flags, arming and pin 0 level as ints
`timescale 1ns/1ps
module timer_status_output_control_test;
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic standby_in = 1'b0;
   logic [1:0] sel = 2'h0;
   logic rd_en = 1'b0;
   logic wr_en = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic [3:0] step = 4'h0;
   logic [3:0] load = 4'h0;
   logic [7:0] load_val = 8'h00;
   logic [31:0] cmp_a = 32'h40404040;
   logic [31:0] cmp_b = 32'h80808080;
   logic [3:0] ena_a = 4'h0, ena_b = 4'h0, ena_o = 4'h0;
   logic cap1 = 1'b0, cap3 = 1'b0, trig_en = 1'b0, ext = 1'b0;
   logic [1:0] cap_load;
   int loads = 0;
   tsoc_pkg::events_t [3:0] events;
   logic [31:0] counter;
   logic [7:0] rdata;
   logic [7:0] st [4];
   logic adc_start;
   logic [3:0] pin, oe, irq_a, irq_b, irq_o;
   logic [15:0] cap_val;
   int err_count = 0;
   int tests_run = 0;
   int seed = 98890;
   int starts = 0;
   int flg [4];
   int ctl [4];
   int armed [4];
   int pin0;

   counter_side_model partner (.clk_in(clk_in), .step_in(step), .load_in(load), .load_val_in(load_val),
      .cmp_a_in(cmp_a), .cmp_b_in(cmp_b), .events_out(events), .counter_out(counter));

   timer_status_output_control dut (.clk_in(clk_in), .reset_in(reset_in), .standby_in(standby_in),
      .reg_sel_in(sel), .reg_rd_in(rd_en), .reg_wr_in(wr_en), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
      .events_in(events), .counter_in(counter), .match_a_irq_enable_in(ena_a),
      .match_b_irq_enable_in(ena_b), .overflow_irq_enable_in(ena_o), .capture_pin1_in(cap1),
      .capture_pin3_in(cap3), .converter_trigger_enable_in(trig_en), .adc_external_trigger_pin_in(ext),
      .adc_start_out(adc_start), .timer_pin_out(pin), .timer_pin_oe_out(oe), .capture_value_out(cap_val),
      .capture_load_out(cap_load), .match_a_interrupt_out(irq_a), .match_b_interrupt_out(irq_b),
      .overflow_interrupt_out(irq_o), .status_ch0_out(st[0]), .status_ch1_out(st[1]),
      .status_ch2_out(st[2]), .status_ch3_out(st[3]));

   initial
   begin
      forever #12.5 clk_in = ~clk_in;
   end

   always @(posedge clk_in)
   begin
      if (adc_start === 1'b1) starts++;
      if (cap_load !== 2'h0) loads++;
   end

   // ****************************************
   // reference model and bus tasks
   // ****************************************
   task automatic m_reset();
      flg = '{0, 0, 0, 0};
      ctl = '{0, 0, 8'h10, 0};
      armed = '{0, 0, 0, 0};
      pin0 = 0;
   endtask : m_reset

   function automatic int exp_oe(input int c);
      return int'(ctl[c][3:0] != 0 && !(c % 2 == 1 && ctl[c][4]));
   endfunction : exp_oe

   task automatic m_event(input int c, input int v);
      int ea;
      int eb;
      int act;
      ea = (v == cmp_a[c*8 +: 8]);
      eb = (v == cmp_b[c*8 +: 8]) && !(c % 2 == 0 && ctl[c+1][4]) && !(c % 2 == 1 && ctl[c][4]);
      flg[c] |= (eb << 7) | (ea << 6) | ((v == 255) << 5);
      act = (c == 0 && ea) ? (ctl[0] & 3) : 0;
      if (c == 0 && eb && ((ctl[0] >> 2) & 3) > act) act = (ctl[0] >> 2) & 3;
      if (act == 1) pin0 = 0;
      else if (act == 2) pin0 = 1;
      else if (act == 3) pin0 = 1 - pin0;
   endtask : m_event

   task automatic chk8(input string n, input int e, input logic [7:0] g);
      tests_run++;
      if (g !== e[7:0])
      begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, e[7:0], g);
      end
   endtask : chk8

   task automatic chk1(input string n, input int e, input logic g);
      tests_run++;
      if (g !== e[0])
      begin
         err_count++;
         $display("MISMATCH %s expected %b seen %b", n, e[0], g);
      end
   endtask : chk1

   task automatic chk_all();
      for (int c = 0; c < 4; c++)
      begin
         chk8("status", flg[c] | ctl[c], st[c]);
         chk1("irq_a", flg[c][6] & ena_a[c], irq_a[c]);
         chk1("irq_b", flg[c][7] & ena_b[c], irq_b[c]);
         chk1("irq_overflow", flg[c][5] & ena_o[c], irq_o[c]);
         chk1("oe", exp_oe(c), oe[c]);
      end
      if (ctl[0][3:0] != 0) chk1("pin0", pin0, pin[0]);
   endtask : chk_all

   task automatic rd(input int c);
      @(posedge clk_in);
      rd_en <= 1'b1;
      sel <= c[1:0];
      @(posedge clk_in);
      rd_en <= 1'b0;
      armed[c] = flg[c];
      repeat (2) @(posedge clk_in);
      #1;
      chk8("rdata", flg[c] | ctl[c], rdata);
   endtask : rd

   task automatic wr(input int c, input int d);
      @(posedge clk_in);
      wr_en <= 1'b1;
      sel <= c[1:0];
      wdata <= d[7:0];
      @(posedge clk_in);
      wr_en <= 1'b0;
      flg[c] &= ~(armed[c] & ~d & 8'he0);
      ctl[c] = d & 8'h1f;
      armed[c] = 0;
      repeat (3) @(posedge clk_in);
      #1;
      chk_all();
   endtask : wr

   // load a counter with v, then step it once; optionally clear flags at the step edge
   task automatic hit(input int c, input int v, input int clr);
      @(posedge clk_in);
      load[c] <= 1'b1;
      load_val <= v[7:0];
      {ena_a, ena_b, ena_o} <= 12'($random(seed));
      @(posedge clk_in);
      load <= 4'h0;
      step[c] <= 1'b1;
      wr_en <= clr[0];
      sel <= c[1:0];
      wdata <= ctl[c][7:0];
      @(posedge clk_in);
      step <= 4'h0;
      wr_en <= 1'b0;
      if (clr) flg[c] &= ~(armed[c] & 8'he0);
      if (clr) armed[c] = 0;
      m_event(c, v);
      repeat (3) @(posedge clk_in);
      #1;
      chk_all();
   endtask : hit

   task automatic clear(input int c);
      rd(c);
      wr(c, ctl[c]);
      rd(c);
   endtask : clear

   // edge on the capture pin of channel 1 or 3; sync latency is covered by the wait
   task automatic cap_edge(input int c, input int lvl, input int yes);
      @(posedge clk_in);
      if (c == 1) cap1 <= lvl[0];
      else cap3 <= lvl[0];
      loads = 0;
      repeat (8) @(posedge clk_in);
      if (yes) flg[c] |= 8'h80;
      #1;
      chk_all();
      chk8("capture_load", yes, loads[7:0]);
      if (yes) chk8("capture", 8'h5b, cap_val[(c / 2) * 8 +: 8]);
   endtask : cap_edge

   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
      begin
         $display("Simulation passed");
      end
      else
      begin
         $display("Simulation failed");
      end
      $finish;
   endtask : conclude

   initial
   begin
      repeat (30000) @(posedge clk_in);
      err_count++;
      conclude();
   end

   initial
   begin
      m_reset();
      repeat (20) @(posedge clk_in);
      reset_in <= 1'b0;
      #1;
      chk_all();
      for (int c = 0; c < 4; c++) rd(c);
      wr(0, 8'he0);
      hit(0, 8'h40, 0);
      wr(0, 8'h00);
      rd(0);
      wr(0, 8'he0);
      rd(0);
      hit(0, 8'h40, 1);
      clear(0);
      hit(0, 8'hff, 0);
      hit(0, 8'h80, 0);
      clear(0);
      for (int k = 0; k < 16; k++)
      begin
         wr(0, k);
         hit(0, 8'h40, 0);
         hit(0, 8'h80, 0);
         cmp_b[7:0] <= 8'h40;
         hit(0, 8'h40, 0);
         cmp_b[7:0] <= 8'h80;
      end
      for (int k = 0; k < 4; k++) wr(2, $random(seed) & 31);
      rd(2);
      hit(1, 8'h5a, 0);
      hit(3, 8'h5a, 0);
      clear(0);
      for (int e = 0; e < 3; e++)
      begin
         wr(1, 8'h10 | (e << 2));
         hit(0, 8'h80, 0);
         hit(0, 8'h40, 0);
         cap_edge(1, 1, e != 1);
         clear(1);
         cap_edge(1, 0, e != 0);
         clear(1);
      end
      wr(1, 8'h00);
      wr(3, 8'h10);
      cap_edge(3, 1, 1);
      clear(3);
      wr(3, 8'h00);
      for (int t = 0; t < 4; t++)
      begin
         trig_en <= t[1];
         wr(0, (t[0] << 4) | 3);
         starts = 0;
         ext <= 1'b1;
         repeat (8) @(posedge clk_in);
         ext <= 1'b0;
         repeat (8) @(posedge clk_in);
         #1;
         chk1("adc_ext", t == 2, starts > 0);
         starts = 0;
         hit(0, 8'h40, 0);
         chk1("adc_match", t == 3, starts > 0);
      end
      standby_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      standby_in <= 1'b0;
      m_reset();
      repeat (3) @(posedge clk_in);
      #1;
      chk_all();
      conclude();
   end
endmodule : timer_status_output_control_test
